/* dv/cpu_side_model.sv */
`timescale 1ns/1ns

// Software side: buffer RAM behind the window and the shared line A interrupt pin
module cpu_side_model (
    input  wire logic       i_clk,       // Clock
    input  wire logic [9:0] i_buf_addr,  // Buffer address
    input  wire logic [7:0] i_buf_wdata, // Buffer write data
    input  wire logic       i_buf_wr,    // Buffer write pulse
    output logic      [7:0] o_buf_rdata, // Buffer read data
    input  wire logic       i_line_a_n,  // Routed line A
    input  wire logic       i_other_a_n, // Other source on line A
    output logic            o_pin_a_n    // Line A pin level
);
    logic [7:0] ram [0:1023];

    // Unwritten cells read unknown, so a missed write shows up
    assign o_buf_rdata = ram[i_buf_addr];
    // Any low source pulls the shared pin low
    assign o_pin_a_n = i_line_a_n & i_other_a_n;

    always_ff @(posedge i_clk) begin
        if (i_buf_wr)
            ram[i_buf_addr] <= i_buf_wdata;
    end
endmodule

/* dv/network_irq_mask_router_chk.sv */
`timescale 1ns/1ns
`include "net_irq_consts.svh"

module network_irq_mask_router_chk (
    input wire logic       i_clk,          // Clock
    input wire logic       i_rstn,         // Reset, active low
    input wire logic [3:0] i_reg_addr,     // Offset
    input wire logic       i_reg_wr,       // Write strobe
    input wire logic [7:0] i_reg_wdata,    // Write data
    input wire logic       i_tx_available, // Live flag
    input wire logic [7:0] o_buf_wdata,    // Buffer data
    input wire logic       o_buf_wr,       // Buffer write
    input wire logic       o_double_rate,  // Rate select
    input wire logic       o_irq,          // Interrupt
    input wire logic       o_line_a_n,     // Line A
    input wire logic       o_line_b_n,     // Line B
    input wire logic [7:0] o_port_pin      // Port pins
);
    logic [7:0] mask;
    logic [7:0] routing;
    wire        mask_wr    = i_reg_wr && (i_reg_addr == `OFS_STATUS_MASK);
    wire        route_wr   = i_reg_wr && (i_reg_addr == `OFS_ROUTING);
    wire        lines_idle = o_line_a_n && o_line_b_n;

    // Shadow copies, so routing checks need no view inside the block
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mask    <= `RST_MASK;
            routing <= `RST_ROUTING;
        end else begin
            if (mask_wr)
                mask <= i_reg_wdata & `MASK_IRQ_CAPABLE;
            if (route_wr)
                routing <= i_reg_wdata & `ROUTING_WRITE_MASK;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence data_write;
        i_reg_wr && (i_reg_addr == `OFS_DATA);
    endsequence
    sequence buf_pulse;
        o_buf_wr && (o_buf_wdata == $past(i_reg_wdata));
    endsequence

    idle_release_a:
        assert property (!o_irq |-> lines_idle && (o_port_pin == 8'h00))
        else $error("routed output active while idle");
    line_a_a:
        assert property (routing[0] && o_irq |-> !o_line_a_n && o_line_b_n && (o_port_pin == 8'h00))
        else $error("line A not driven alone");
    line_b_a:
        assert property (routing[1:0] == 2'b10 && o_irq |-> o_line_a_n && !o_line_b_n)
        else $error("line B not driven alone");
    port_pin_a:
        assert property (routing[2:0] == 3'b100 && o_irq |-> lines_idle
                         && (o_port_pin == (8'h01 << routing[5:3])))
        else $error("wrong port pin");
    rate_follow_a:
        assert property (o_double_rate == routing[6])
        else $error("rate select differs from routing");
    tx_unmask_a:
        assert property (i_tx_available && mask[0] |-> o_irq)
        else $error("enabled flag gives no interrupt");
    mask_gate_a:
        assert property (mask == 8'h00 |-> !o_irq)
        else $error("interrupt with empty mask");
    data_pass_a:
        assert property (data_write |=> buf_pulse)
        else $error("data write not passed to buffer");
endmodule

bind network_irq_mask_router network_irq_mask_router_chk u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_tx_available(i_tx_available), .o_buf_wdata(o_buf_wdata),
    .o_buf_wr(o_buf_wr), .o_double_rate(o_double_rate), .o_irq(o_irq),
    .o_line_a_n(o_line_a_n), .o_line_b_n(o_line_b_n), .o_port_pin(o_port_pin)
);

/* dv/test_network_irq_mask_router.sv */
`timescale 1ns/1ns
`include "net_irq_consts.svh"

module test_network_irq_mask_router;
    logic       i_clk, i_rstn, i_reg_wr, i_reg_rd, i_soft_reset, i_recv_inhibited;
    logic       i_tx_available, i_reconfig_set, i_excess_nak_set, i_succ_update;
    logic       o_buf_wr, o_double_rate, o_irq, o_line_a_n, o_line_b_n, other_a_n, pin_a_n;
    logic       o_buf_rd, o_command_wr;
    logic [7:0] o_command, o_core_config, o_own_node_id, o_probe_node_id;
    logic [3:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, i_succ_value, i_status_other, i_diag_other;
    logic [7:0] i_buf_rdata, o_buf_wdata, o_core_setup, o_port_pin;
    logic [9:0] o_buf_addr;
    int         fail_count = 0;
    int         samples_checked = 0;

    network_irq_mask_router u_network_irq_mask_router (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_soft_reset(i_soft_reset), .i_recv_inhibited(i_recv_inhibited),
        .i_tx_available(i_tx_available), .i_reconfig_set(i_reconfig_set),
        .i_excess_nak_set(i_excess_nak_set), .i_succ_update(i_succ_update),
        .i_succ_value(i_succ_value), .i_status_other(i_status_other),
        .i_diag_other(i_diag_other), .i_buf_rdata(i_buf_rdata), .o_buf_addr(o_buf_addr),
        .o_buf_wdata(o_buf_wdata), .o_buf_wr(o_buf_wr), .o_buf_rd(o_buf_rd),
        .o_command(o_command), .o_command_wr(o_command_wr),
        .o_double_rate(o_double_rate), .o_core_config(o_core_config),
        .o_core_setup(o_core_setup), .o_own_node_id(o_own_node_id),
        .o_probe_node_id(o_probe_node_id), .o_irq(o_irq),
        .o_line_a_n(o_line_a_n), .o_line_b_n(o_line_b_n), .o_port_pin(o_port_pin));

    cpu_side_model u_cpu_side_model (
        .i_clk(i_clk), .i_buf_addr(o_buf_addr), .i_buf_wdata(o_buf_wdata),
        .i_buf_wr(o_buf_wr), .o_buf_rdata(i_buf_rdata), .i_line_a_n(o_line_a_n),
        .i_other_a_n(other_a_n), .o_pin_a_n(pin_a_n));

    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        i_reg_addr  <= addr;
        i_reg_wdata <= data;
        i_reg_wr    <= 1'b1;
        @(posedge i_clk);
        i_reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic expect_read(input logic [3:0] addr, input logic [7:0] exp);
        @(posedge i_clk);
        i_reg_addr <= addr;
        i_reg_rd   <= 1'b1;
        @(posedge i_clk);
        i_reg_rd   <= 1'b0;
        #1;
        check(10'(o_reg_rdata), 10'(exp));
    endtask

    task automatic test_reset_values();
        check(10'(o_irq), 10'h000);
        expect_read(`OFS_ROUTING, 8'h00);
        expect_read(4'hC, 8'h00);
        check({o_line_a_n, o_line_b_n, o_port_pin}, 10'h300);
        reg_write(`OFS_STATUS_MASK, 8'hFF);
        i_tx_available <= 1'b0;
        #10;
        check(10'(o_irq), 10'h000);
        $display("test_reset_values done");
    endtask

    task automatic test_mask_hide();
        reg_write(`OFS_STATUS_MASK, 8'h01);
        i_tx_available <= 1'b1;
        #10;
        check(10'(o_irq), 10'h001);
        reg_write(`OFS_STATUS_MASK, 8'h00);
        check(10'(o_irq), 10'h000);
        reg_write(`OFS_STATUS_MASK, 8'h80);
        i_recv_inhibited <= 1'b1;
        #10;
        check(10'(o_irq), 10'h001);
        reg_write(`OFS_STATUS_MASK, 8'h01);
        i_recv_inhibited <= 1'b0;
        check(10'(o_irq), 10'h001);
        $display("test_mask_hide done");
    endtask

    task automatic test_routing();
        reg_write(`OFS_ROUTING, 8'h07);
        check({o_line_a_n, o_line_b_n, o_port_pin}, 10'h100);
        check(10'(pin_a_n), 10'h000);
        reg_write(`OFS_ROUTING, 8'h06);
        check({o_line_a_n, o_line_b_n, o_port_pin}, 10'h200);
        for (int k = 0; k < 8; k++) begin
            reg_write(`OFS_ROUTING, {2'b00, 3'(k), 3'b100});
            check({o_line_a_n, o_line_b_n, o_port_pin}, {2'b11, 8'h01 << k});
        end
        reg_write(`OFS_CONFIG, 8'h1A);
        reg_write(`OFS_SETUP, 8'h01);
        check(10'(o_core_setup), 10'h001);
        reg_write(`OFS_CONFIG, 8'h19);
        reg_write(`OFS_SETUP, 8'h42);
        check(10'(o_own_node_id), 10'h042);
        reg_write(`OFS_CONFIG, 8'h18);
        check(10'(o_core_config), 10'h018);
        reg_write(`OFS_SETUP, 8'h24);
        check(10'(o_probe_node_id), 10'h024);
        expect_read(`OFS_SETUP, 8'h24);
        check(10'(o_core_setup), 10'h001);
        reg_write(`OFS_ROUTING, 8'hFF);
        check(10'(o_double_rate), 10'h001);
        expect_read(`OFS_ROUTING, 8'h7F);
        reg_write(`OFS_ROUTING, 8'h00);
        check(10'(o_double_rate), 10'h000);
        $display("test_routing done");
    endtask

    task automatic test_sticky();
        i_tx_available <= 1'b0;
        i_reconfig_set <= 1'b1;
        @(posedge i_clk);
        i_reconfig_set <= 1'b0;
        reg_write(`OFS_STATUS_MASK, 8'h04);
        check(10'(o_irq), 10'h001);
        reg_write(`OFS_DIAG_COMMAND, `CMD_CLEAR_FLAGS);
        check(10'(o_irq), 10'h000);
        check(10'({o_command_wr, o_command}), 10'h11E);
        i_excess_nak_set <= 1'b1;
        @(posedge i_clk);
        i_excess_nak_set <= 1'b0;
        reg_write(`OFS_STATUS_MASK, 8'h08);
        reg_write(`OFS_DIAG_COMMAND, `CMD_CLEAR_FLAGS);
        check(10'(o_irq), 10'h001);
        reg_write(`OFS_DIAG_COMMAND, `CMD_POR_CLEAR_FLAGS);
        check(10'(o_irq), 10'h000);
        i_succ_update <= 1'b1;
        @(posedge i_clk);
        i_succ_update <= 1'b0;
        reg_write(`OFS_STATUS_MASK, 8'h02);
        check(10'(o_irq), 10'h001);
        reg_write(`OFS_CONFIG, 8'h1B);
        expect_read(`OFS_SETUP, 8'h5A);
        check(10'(o_irq), 10'h000);
        $display("test_sticky done");
    endtask

    task automatic test_buffer_and_resets();
        reg_write(`OFS_PTR_HIGH, 8'h02);
        reg_write(`OFS_PTR_LOW, 8'h34);
        check(o_buf_addr, 10'h234);
        reg_write(`OFS_DATA, 8'hA5);
        reg_write(`OFS_PTR_LOW, 8'h35);
        reg_write(`OFS_DATA, 8'h3C);
        reg_write(`OFS_PTR_LOW, 8'h34);
        expect_read(`OFS_DATA, 8'hA5);
        check(10'(o_buf_rd), 10'h001);
        reg_write(`OFS_STATUS_MASK, 8'h01);
        i_tx_available <= 1'b1;
        i_soft_reset   <= 1'b1;
        @(posedge i_clk);
        i_soft_reset   <= 1'b0;
        #1;
        check(10'(o_irq), 10'h001);
        @(posedge i_clk);
        i_rstn <= 1'b0;
        @(posedge i_clk);
        i_rstn <= 1'b1;
        #1;
        check(10'(o_irq), 10'h000);
        $display("test_buffer_and_resets done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        {i_rstn, i_reg_wr, i_reg_rd, i_soft_reset, i_recv_inhibited} = '0;
        {i_reconfig_set, i_excess_nak_set, i_succ_update} = '0;
        {i_tx_available, other_a_n} = 2'b11;
        i_reg_addr     = 4'h0;
        i_reg_wdata    = 8'h00;
        i_succ_value   = 8'h5A;
        i_status_other = 8'hFF;
        i_diag_other   = 8'hFF;
        repeat (6) @(posedge i_clk);
        i_rstn <= 1'b1;
        test_reset_values();
        test_mask_hide();
        test_routing();
        test_sticky();
        test_buffer_and_resets();
        stop_test();
    end

    // The tests need about a hundred cycles; this leaves wide margin
    initial begin
        #50000;
        fail_count++;
        stop_test();
    end
endmodule

/* src/irq_combiner.sv */
`timescale 1ns/1ns
`include "net_irq_consts.svh"

// Masked flag combine: only the five capable positions take part
module irq_combiner (
    input  wire logic [7:0] i_status_view,  // Flags in their status or diagnostic positions
    input  wire logic [7:0] i_mask,         // Interrupt enable mask
    output logic            o_irq            // Combined interrupt, active high
);
    wire [7:0] capable_flags = i_status_view & `MASK_IRQ_CAPABLE;
    wire [7:0] enabled_flags = capable_flags & i_mask;

    assign o_irq = |enabled_flags;
endmodule

/* src/irq_router.sv */
`timescale 1ns/1ns
`include "net_irq_consts.svh"

module irq_router (
    input  wire logic       i_irq,      // Combined interrupt
    input  wire logic [7:0] i_routing,  // Routing register
    output logic            o_line_a_n, // Line A drive low request
    output logic            o_line_b_n, // Line B drive low request
    output logic [7:0]      o_port_pin  // One-hot port pin interrupt
);
    wire en_a    = i_routing[`BIT_LINE_A_EN];
    wire en_b    = i_routing[`BIT_LINE_B_EN];
    wire en_port = i_routing[`BIT_PORT_ROUTE_EN];
    wire [2:0] pin_sel = i_routing[`PIN_SEL_MSB:`PIN_SEL_LSB];

    net_irq_pkg::route_sel_t route;

    // Fixed priority: line A, then line B, then the port pin
    assign route = en_a ? net_irq_pkg::ROUTE_LINE_A :
                   en_b ? net_irq_pkg::ROUTE_LINE_B :
                   net_irq_pkg::ROUTE_PORT;

    wire drive_a    = i_irq && en_a;
    wire drive_b    = i_irq && route == net_irq_pkg::ROUTE_LINE_B;
    wire drive_port = i_irq && en_port && route == net_irq_pkg::ROUTE_PORT;

    // Inactive level is high so the line stays shareable
    assign o_line_a_n = ~drive_a;
    assign o_line_b_n = ~drive_b;
    assign o_port_pin = drive_port ? (8'h01 << pin_sel) : 8'h00;
endmodule

/* src/net_irq_consts.svh */
`ifndef NET_IRQ_CONSTS_SVH
`define NET_IRQ_CONSTS_SVH

// Register offsets on the internal register port
`define OFS_STATUS_MASK      4'h0
`define OFS_DIAG_COMMAND     4'h1
`define OFS_PTR_HIGH         4'h2
`define OFS_PTR_LOW          4'h3
`define OFS_DATA             4'h4
`define OFS_RESERVED_A       4'h5
`define OFS_CONFIG           4'h6
`define OFS_SETUP            4'h7
`define OFS_RESERVED_B       4'h8
`define OFS_ROUTING          4'h9

// Flag positions, shared by the mask and the status or diagnostic register
`define BIT_RECV_INHIBITED   7
`define BIT_EXCESS_NAK       3
`define BIT_RECONFIG         2
`define BIT_SUCC_CHANGED     1
`define BIT_TX_AVAILABLE     0

// Mask of the bits that may interrupt
`define MASK_IRQ_CAPABLE     8'h8F

// Routing register fields
`define BIT_LINE_A_EN        0
`define BIT_LINE_B_EN        1
`define BIT_PORT_ROUTE_EN    2
`define PIN_SEL_LSB          3
`define PIN_SEL_MSB          5
`define BIT_DOUBLE_RATE      6
`define ROUTING_WRITE_MASK   8'h7F

// Configuration register: sub-address field
`define CFG_SUBADDR_LSB      0
`define CFG_SUBADDR_MSB      1

// Sub-address codes for offset 7
`define SUB_PROBE_OR_SETUP   2'h0
`define SUB_OWN_ID           2'h1
`define SUB_SETUP            2'h2
`define SUB_SUCCESSOR        2'h3

// Reset values
`define RST_MASK             8'h00
`define RST_ROUTING          8'h00
`define RST_CONFIG           8'h18
`define RST_SETUP            8'h00
`define RST_ID               8'h00

// Command codes
`define CMD_CLEAR_FLAGS      8'h1E
`define CMD_POR_CLEAR_FLAGS  8'h1F

// Buffer memory size
`define BUF_ADDR_W           10

// Network core clock rates in MHz
`define CORE_CLK_BASE_MHZ    20
`define CORE_CLK_FAST_MHZ    40

`endif

/* src/net_irq_pkg.sv */
package net_irq_pkg;
    typedef enum logic [2:0] {
        ROUTE_LINE_A = 3'b001,
        ROUTE_LINE_B = 3'b010,
        ROUTE_PORT   = 3'b100
    } route_sel_t;

    typedef logic [7:0] reg_byte_t;
endpackage

/* src/network_irq_mask_router.sv */
`timescale 1ns/1ns
`include "net_irq_consts.svh"

module network_irq_mask_router (
    input  wire logic       i_clk,             // System clock, 100 MHz
    input  wire logic       i_rstn,            // Hardware reset, active low
    input  wire logic [3:0] i_reg_addr,        // Register offset
    input  wire logic       i_reg_wr,          // Register write strobe
    input  wire logic       i_reg_rd,          // Register read strobe
    input  wire logic [7:0] i_reg_wdata,       // Register write data
    output logic      [7:0] o_reg_rdata,       // Register read data
    input  wire logic       i_soft_reset,      // Core software reset pulse
    input  wire logic       i_recv_inhibited,  // Receiver inhibited level
    input  wire logic       i_tx_available,    // Transmitter available level
    input  wire logic       i_reconfig_set,    // Reconfiguration event pulse
    input  wire logic       i_excess_nak_set,  // Excess NAK event pulse
    input  wire logic       i_succ_update,     // Sequencer successor update pulse
    input  wire logic [7:0] i_succ_value,      // New successor identifier
    input  wire logic [7:0] i_status_other,    // Other status bits 6..3,1
    input  wire logic [7:0] i_diag_other,      // Other diagnostic bits
    input  wire logic [7:0] i_buf_rdata,       // Buffer memory read data
    output logic      [9:0] o_buf_addr,        // Buffer memory address
    output logic      [7:0] o_buf_wdata,       // Buffer memory write data
    output logic            o_buf_wr,          // Buffer memory write pulse
    output logic            o_buf_rd,          // Buffer memory read pulse
    output logic      [7:0] o_command,         // Command byte
    output logic            o_command_wr,      // Command write pulse
    output logic            o_double_rate,     // Core clock 40 MHz select
    output logic      [7:0] o_core_config,     // Configuration register
    output logic      [7:0] o_core_setup,      // Setup register
    output logic      [7:0] o_own_node_id,     // Own node identifier
    output logic      [7:0] o_probe_node_id,   // Probe node identifier
    output logic            o_irq,             // Combined interrupt, active high
    output logic            o_line_a_n,        // Processor line A, active low
    output logic            o_line_b_n,        // Processor line B, active low
    output logic      [7:0] o_port_pin         // Port pin interrupt outputs
);
    net_irq_pkg::reg_byte_t interrupt_enable_mask;
    net_irq_pkg::reg_byte_t interrupt_routing;
    net_irq_pkg::reg_byte_t core_configuration;
    net_irq_pkg::reg_byte_t network_setup;
    net_irq_pkg::reg_byte_t probe_node_id;
    net_irq_pkg::reg_byte_t own_node_id;
    net_irq_pkg::reg_byte_t successor_id;
    logic                   reconfiguration_flag;
    logic                   excess_nak_flag;
    logic                   successor_changed_flag;
    logic [1:0]             buffer_pointer_high;
    logic [7:0]             buffer_pointer_low;
    logic [9:0]             buffer_address;
    logic [7:0]             buffer_data_window;
    logic [7:0]             read_mux;
    logic [7:0]             status_view;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    wire [1:0] subaddr = core_configuration[`CFG_SUBADDR_MSB:`CFG_SUBADDR_LSB];

    wire wr_mask    = i_reg_wr && hit(i_reg_addr, `OFS_STATUS_MASK);
    wire wr_command = i_reg_wr && hit(i_reg_addr, `OFS_DIAG_COMMAND);
    wire wr_ptr_hi  = i_reg_wr && hit(i_reg_addr, `OFS_PTR_HIGH);
    wire wr_ptr_lo  = i_reg_wr && hit(i_reg_addr, `OFS_PTR_LOW);
    wire wr_data    = i_reg_wr && hit(i_reg_addr, `OFS_DATA);
    wire wr_config  = i_reg_wr && hit(i_reg_addr, `OFS_CONFIG);
    wire wr_shared  = i_reg_wr && hit(i_reg_addr, `OFS_SETUP);
    wire wr_routing = i_reg_wr && hit(i_reg_addr, `OFS_ROUTING);
    wire rd_data    = i_reg_rd && hit(i_reg_addr, `OFS_DATA);

    // Offset 7 is shared among setup and the identifier registers
    wire wr_setup   = wr_shared && (subaddr == `SUB_SETUP);
    wire wr_own     = wr_shared && (subaddr == `SUB_OWN_ID);
    wire wr_prb     = wr_shared && (subaddr == `SUB_PROBE_OR_SETUP);
    wire rd_succ    = i_reg_rd && hit(i_reg_addr, `OFS_SETUP)
                      && (subaddr == `SUB_SUCCESSOR);

    wire cmd_clear     = wr_command && (i_reg_wdata == `CMD_CLEAR_FLAGS);
    wire cmd_por_clear = wr_command && (i_reg_wdata == `CMD_POR_CLEAR_FLAGS);

    // Mask: hardware reset only; soft reset deliberately not applied
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            interrupt_enable_mask <= `RST_MASK;
        end else if (wr_mask) begin
            interrupt_enable_mask <= i_reg_wdata & `MASK_IRQ_CAPABLE;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            interrupt_routing <= `RST_ROUTING;
        end else if (wr_routing) begin
            interrupt_routing <= i_reg_wdata & `ROUTING_WRITE_MASK;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            core_configuration <= `RST_CONFIG;
            network_setup      <= `RST_SETUP;
            probe_node_id      <= `RST_ID;
            own_node_id        <= `RST_ID;
        end else begin
            if (wr_config) begin
                core_configuration <= i_reg_wdata;
            end
            if (wr_setup) begin
                network_setup <= i_reg_wdata;
            end
            if (wr_prb) begin
                probe_node_id <= i_reg_wdata;
            end
            if (wr_own) begin
                own_node_id <= i_reg_wdata;
            end
        end
    end

    // Successor register follows the sequencer; cleared by either reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            successor_id <= `RST_ID;
        end else if (i_soft_reset) begin
            successor_id <= `RST_ID;
        end else if (i_succ_update) begin
            successor_id <= i_succ_value;
        end
    end

    // Event flags: a set in the same cycle as its clear wins
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            reconfiguration_flag   <= 1'b0;
            excess_nak_flag        <= 1'b0;
            successor_changed_flag <= 1'b0;
        end else begin
            if (i_reconfig_set) begin
                reconfiguration_flag <= 1'b1;
            end else if (cmd_clear || cmd_por_clear || i_soft_reset) begin
                reconfiguration_flag <= 1'b0;
            end
            if (i_excess_nak_set) begin
                excess_nak_flag <= 1'b1;
            end else if (cmd_por_clear) begin
                excess_nak_flag <= 1'b0;
            end
            if (i_succ_update) begin
                successor_changed_flag <= 1'b1;
            end else if (rd_succ) begin
                successor_changed_flag <= 1'b0;
            end
        end
    end

    // Pointer: high part is staged, low write commits the whole address
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            buffer_pointer_high <= 2'h0;
            buffer_pointer_low  <= 8'h00;
            buffer_address      <= 10'h000;
        end else begin
            if (wr_ptr_hi) begin
                buffer_pointer_high <= i_reg_wdata[1:0];
            end
            if (wr_ptr_lo) begin
                buffer_pointer_low <= i_reg_wdata;
                buffer_address     <= {buffer_pointer_high, i_reg_wdata};
            end
        end
    end

    // Data window: one byte at the current address per access
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            buffer_data_window <= 8'h00;
            o_buf_wr           <= 1'b0;
            o_buf_rd           <= 1'b0;
        end else begin
            o_buf_wr <= wr_data;
            o_buf_rd <= rd_data;
            if (wr_data) begin
                buffer_data_window <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_command    <= 8'h00;
            o_command_wr <= 1'b0;
            o_reg_rdata  <= 8'h00;
        end else begin
            o_command_wr <= wr_command;
            if (wr_command) begin
                o_command <= i_reg_wdata;
            end
            if (i_reg_rd) begin
                o_reg_rdata <= read_mux;
            end
        end
    end

    // Status view: only the five capable bits come from live flags
    assign status_view = {i_recv_inhibited,
                          i_status_other[6:4],
                          excess_nak_flag,
                          reconfiguration_flag,
                          successor_changed_flag,
                          i_tx_available};

    wire [7:0] status_byte = {i_recv_inhibited, i_status_other[6:3],
                              reconfiguration_flag, i_status_other[1], i_tx_available};
    wire [7:0] diag_byte   = {i_diag_other[7:4], excess_nak_flag,
                              i_diag_other[2], successor_changed_flag, i_diag_other[0]};
    wire [7:0] shared_byte = (subaddr == `SUB_SUCCESSOR) ? successor_id :
                             (subaddr == `SUB_OWN_ID)    ? own_node_id  :
                             (subaddr == `SUB_SETUP)     ? network_setup :
                             probe_node_id;

    always_comb begin
        case (i_reg_addr)
            `OFS_STATUS_MASK:  read_mux = status_byte;
            `OFS_DIAG_COMMAND: read_mux = diag_byte;
            `OFS_PTR_HIGH:     read_mux = {6'h00, buffer_pointer_high};
            `OFS_PTR_LOW:      read_mux = buffer_pointer_low;
            `OFS_DATA:         read_mux = i_buf_rdata;
            `OFS_CONFIG:       read_mux = core_configuration;
            `OFS_SETUP:        read_mux = shared_byte;
            `OFS_ROUTING:      read_mux = interrupt_routing;
            default:           read_mux = 8'h00;
        endcase
    end

    assign o_buf_addr      = buffer_address;
    assign o_buf_wdata     = buffer_data_window;
    assign o_double_rate   = interrupt_routing[`BIT_DOUBLE_RATE];
    assign o_core_config   = core_configuration;
    assign o_core_setup    = network_setup;
    assign o_own_node_id   = own_node_id;
    assign o_probe_node_id = probe_node_id;

    irq_combiner u_combiner (
        .i_status_view (status_view),
        .i_mask        (interrupt_enable_mask),
        .o_irq         (o_irq)
    );

    irq_router u_router (
        .i_irq      (o_irq),
        .i_routing  (interrupt_routing),
        .o_line_a_n (o_line_a_n),
        .o_line_b_n (o_line_b_n),
        .o_port_pin (o_port_pin)
    );
endmodule
